/* rtl/dcau_regs.svh */
// reset values, status word layout and shifter codes of the arithmetic datapath
`ifndef DCAU_REGS_SVH
`define DCAU_REGS_SVH

`define DCAU_ACC_RST 32'h0000_0000
`define DCAU_PROD_RST 32'h0000_0000
`define DCAU_MCAND_RST 16'h0000
`define DCAU_DOUT_RST 16'h0000
`define DCAU_SAT_MAX 32'h7FFF_FFFF
`define DCAU_SAT_MIN 32'h8000_0000
`define DCAU_HALF_ZERO 16'h0000
`define DCAU_ST_WRAP_BIT 15
`define DCAU_ST_SAT_BIT 14
`define DCAU_ST_RSVD 14'h3FFF
`define DCAU_OSH_AMT0 5'h00
`define DCAU_OSH_AMT1 5'h01
`define DCAU_OSH_AMT4 5'h04
`define DCAU_KONST_W 13
`define DCAU_MUL_MIN_WORD 16'h8000
`define DCAU_MUL_CORNER 32'h0C00_0000
`define DCAU_DATA_W 16

`endif

/* rtl/dcau_pkg.sv */
// types of the central arithmetic datapath
package dcau_pkg;

    typedef enum logic [4:0] {
        OP_NOP = 5'h00, OP_LOAD_SHIFTED = 5'h01, OP_ADD = 5'h02, OP_SUB = 5'h03,
        OP_ADD_NO_SIGN_EXTEND = 5'h04, OP_SUBTRACT_NO_SIGN_EXTEND = 5'h05,
        OP_XOR = 5'h06, OP_AND = 5'h07, OP_OR = 5'h08,
        OP_STORE_HIGH_WORD = 5'h09, OP_STORE_LOW_WORD = 5'h0A,
        OP_SET_SATURATION = 5'h0B, OP_CLEAR_SATURATION = 5'h0C,
        OP_BRANCH_ON_WRAP = 5'h0D, OP_BRANCH_COND = 5'h0E,
        OP_LOAD_STATUS = 5'h0F, OP_STORE_STATUS = 5'h10,
        OP_LOAD_MULTIPLICAND = 5'h11, OP_LOAD_MULTIPLICAND_ADD_PRODUCT = 5'h12,
        OP_MULTIPLY_BY_WORD = 5'h13, OP_MULTIPLY_BY_CONSTANT = 5'h14,
        OP_LOAD_PRODUCT = 5'h15, OP_ADD_PRODUCT = 5'h16, OP_SUBTRACT_PRODUCT = 5'h17
    } dcau_op_t;

    // output shifter amounts; code 3 is not a supported encoding
    typedef enum logic [1:0] {
        OSH_0 = 2'h0, OSH_1 = 2'h1, OSH_4 = 2'h2, OSH_BAD = 2'h3
    } dcau_oshift_t;

    typedef enum logic [2:0] {
        BR_IF_NEGATIVE = 3'h0, BR_IF_NOT_POSITIVE = 3'h1, BR_IF_NOT_NEGATIVE = 3'h2,
        BR_IF_POSITIVE = 3'h3, BR_IF_NONZERO = 3'h4, BR_IF_ZERO = 3'h5
    } dcau_cond_t;

    typedef struct packed {
        dcau_op_t op;
        logic [4:0] in_shift;
        dcau_oshift_t out_shift;
        dcau_cond_t cond;
        logic [12:0] konst;
    } dcau_cmd_t;

    typedef struct packed {
        logic [31:0] val;
        logic ovf;
    } dcau_alu_t;

endpackage

/* rtl/dcau_core.sv */
// central arithmetic unit: ALU, accumulator, shifters, multiplier and branch tests
`timescale 1ns/1ps
`include "dcau_regs.svh"

module dcau_core import dcau_pkg::*; #(
    parameter int DATA_W = `DCAU_DATA_W
) (
    input wire logic CLK, // processor clock
    input wire logic RSTN, // synchronous reset, active low
    input wire logic CMD_VALID, // one instruction this cycle
    input wire dcau_cmd_t CMD, // decoded instruction
    input wire logic [DATA_W-1:0] DATA_IN, // data memory word
    output logic [31:0] ACC, // accumulator
    output logic [31:0] PRODUCT, // product register
    output logic [DATA_W-1:0] MCAND, // multiplicand register
    output logic [DATA_W-1:0] DATA_OUT, // word to store
    output logic DATA_OUT_VALID, // store word valid, one cycle
    output logic BRANCH_VALID, // branch answer valid, one cycle
    output logic BRANCH_TAKEN, // branch condition held
    output logic WRAP_FLAG, // sticky overflow flag
    output logic SAT_ENABLE, // saturation enable
    output logic INT_BLOCK // interrupt recognition blocked
);

    // ---------------------------------------------------------------
    // elaboration check
    // ---------------------------------------------------------------
    if (DATA_W != 16) begin : g_bad_width
        $error("dcau_core serves only 16-bit data words");
    end

    // ---------------------------------------------------------------
    // functions
    // ---------------------------------------------------------------
    function automatic logic [31:0] in_shifter(input logic [15:0] w, input logic [4:0] sh);
        logic [31:0] ext;
        ext = {{16{w[15]}}, w};
        return ext << sh;
    endfunction

    // overflow judged on the raw sum, then optional clamp
    function automatic dcau_alu_t addsub(input logic [31:0] a, input logic [31:0] b,
                                         input logic sub, input logic sat);
        dcau_alu_t r;
        logic [31:0] s;
        s = sub ? a - b : a + b;
        r.ovf = sub ? ((a[31] != b[31]) && (s[31] != a[31]))
                    : ((a[31] == b[31]) && (s[31] != a[31]));
        r.val = s;
        if (r.ovf && sat) begin
            r.val = a[31] ? `DCAU_SAT_MIN : `DCAU_SAT_MAX;
        end
        return r;
    endfunction

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    logic [31:0] acc_reg, acc_next;
    logic [31:0] prod_reg, prod_next;
    logic [15:0] mcand_reg, mcand_next;
    logic [15:0] dout_reg, dout_next;
    logic dout_vld_reg, dout_vld_next;
    logic br_vld_reg, br_vld_next;
    logic br_tkn_reg, br_tkn_next;
    logic wrap_reg, wrap_next;
    logic sat_reg, sat_next;
    logic intb_reg, intb_next;

    dcau_alu_t alu;
    logic [31:0] shifted_in;
    logic [31:0] out_shifted;
    logic [4:0] osh_amt;
    logic [31:0] mul_b;
    logic cond_hit;
    logic is_mul;

    // ---------------------------------------------------------------
    // operand paths
    // ---------------------------------------------------------------
    always_comb begin
        shifted_in = in_shifter(DATA_IN, CMD.in_shift);
        case (CMD.out_shift)
            OSH_0: osh_amt = `DCAU_OSH_AMT0;
            OSH_1: osh_amt = `DCAU_OSH_AMT1;
            OSH_4: osh_amt = `DCAU_OSH_AMT4;
            default: osh_amt = `DCAU_OSH_AMT0;
        endcase
        // low-word bits move up, bits past 31 drop off
        out_shifted = acc_reg << osh_amt;
        mul_b = (CMD.op == OP_MULTIPLY_BY_CONSTANT)
              ? {{19{CMD.konst[12]}}, CMD.konst}
              : {{16{DATA_IN[15]}}, DATA_IN};
        is_mul = CMD_VALID && ((CMD.op == OP_MULTIPLY_BY_WORD) ||
                               (CMD.op == OP_MULTIPLY_BY_CONSTANT));
        case (CMD.cond)
            BR_IF_NEGATIVE: cond_hit = acc_reg[31];
            BR_IF_NOT_POSITIVE: cond_hit = acc_reg[31] || (acc_reg == 32'h0000_0000);
            BR_IF_NOT_NEGATIVE: cond_hit = !acc_reg[31];
            BR_IF_POSITIVE: cond_hit = !acc_reg[31] && (acc_reg != 32'h0000_0000);
            BR_IF_NONZERO: cond_hit = acc_reg != 32'h0000_0000;
            BR_IF_ZERO: cond_hit = acc_reg == 32'h0000_0000;
            default: cond_hit = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // next-state logic
    // ---------------------------------------------------------------
    always_comb begin
        acc_next = acc_reg;
        prod_next = prod_reg;
        mcand_next = mcand_reg;
        dout_next = dout_reg;
        dout_vld_next = 1'b0;
        br_vld_next = 1'b0;
        br_tkn_next = 1'b0;
        wrap_next = wrap_reg;
        sat_next = sat_reg;
        alu.val = acc_reg;
        alu.ovf = 1'b0;
        // block holds through the instruction after the multiply
        intb_next = is_mul ? 1'b1 : (CMD_VALID ? 1'b0 : intb_reg);
        if (CMD_VALID) begin
            case (CMD.op)
                OP_LOAD_SHIFTED: acc_next = shifted_in;
                OP_ADD: alu = addsub(acc_reg, shifted_in, 1'b0, sat_reg);
                OP_SUB: alu = addsub(acc_reg, shifted_in, 1'b1, sat_reg);
                OP_ADD_NO_SIGN_EXTEND: begin
                    alu = addsub(acc_reg, {16'h0000, DATA_IN}, 1'b0, sat_reg);
                end
                OP_SUBTRACT_NO_SIGN_EXTEND: begin
                    alu = addsub(acc_reg, {16'h0000, DATA_IN}, 1'b1, sat_reg);
                end
                // logic results bypass the overflow path entirely
                OP_XOR: acc_next = {`DCAU_HALF_ZERO ^ acc_reg[31:16],
                                    DATA_IN ^ acc_reg[15:0]};
                OP_AND: acc_next = {`DCAU_HALF_ZERO & acc_reg[31:16],
                                    DATA_IN & acc_reg[15:0]};
                OP_OR: acc_next = {`DCAU_HALF_ZERO | acc_reg[31:16],
                                   DATA_IN | acc_reg[15:0]};
                OP_STORE_HIGH_WORD: begin
                    dout_next = out_shifted[31:16];
                    dout_vld_next = 1'b1;
                end
                OP_STORE_LOW_WORD: begin
                    dout_next = acc_reg[15:0];
                    dout_vld_next = 1'b1;
                end
                OP_SET_SATURATION: sat_next = 1'b1;
                OP_CLEAR_SATURATION: sat_next = 1'b0;
                OP_BRANCH_ON_WRAP: begin
                    br_vld_next = 1'b1;
                    br_tkn_next = wrap_reg;
                    wrap_next = 1'b0;
                end
                OP_BRANCH_COND: begin
                    br_vld_next = 1'b1;
                    br_tkn_next = cond_hit;
                end
                OP_LOAD_STATUS: begin
                    wrap_next = DATA_IN[`DCAU_ST_WRAP_BIT];
                    sat_next = DATA_IN[`DCAU_ST_SAT_BIT];
                end
                OP_STORE_STATUS: begin
                    dout_next = {wrap_reg, sat_reg, `DCAU_ST_RSVD};
                    dout_vld_next = 1'b1;
                end
                OP_LOAD_MULTIPLICAND: mcand_next = DATA_IN;
                OP_LOAD_MULTIPLICAND_ADD_PRODUCT: begin
                    mcand_next = DATA_IN;
                    alu = addsub(acc_reg, prod_reg, 1'b0, sat_reg);
                end
                // the 8000h x 8000h corner gives a fixed word, not the true square
                OP_MULTIPLY_BY_WORD, OP_MULTIPLY_BY_CONSTANT: begin
                    if ((mcand_reg == `DCAU_MUL_MIN_WORD) &&
                        (mul_b == {16'hFFFF, `DCAU_MUL_MIN_WORD})) begin
                        prod_next = `DCAU_MUL_CORNER;
                    end else begin
                        prod_next = 32'($signed({{16{mcand_reg[15]}}, mcand_reg})
                                        * $signed(mul_b));
                    end
                end
                OP_LOAD_PRODUCT: acc_next = prod_reg;
                OP_ADD_PRODUCT: alu = addsub(acc_reg, prod_reg, 1'b0, sat_reg);
                OP_SUBTRACT_PRODUCT: alu = addsub(acc_reg, prod_reg, 1'b1, sat_reg);
                default: ;
            endcase
            if (alu.ovf) begin
                acc_next = alu.val;
                wrap_next = 1'b1;
            end else if ((CMD.op == OP_ADD) || (CMD.op == OP_SUB) ||
                         (CMD.op == OP_ADD_NO_SIGN_EXTEND) ||
                         (CMD.op == OP_SUBTRACT_NO_SIGN_EXTEND) ||
                         (CMD.op == OP_LOAD_MULTIPLICAND_ADD_PRODUCT) ||
                         (CMD.op == OP_ADD_PRODUCT) || (CMD.op == OP_SUBTRACT_PRODUCT)) begin
                acc_next = alu.val;
            end
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            acc_reg <= `DCAU_ACC_RST;
            prod_reg <= `DCAU_PROD_RST;
            mcand_reg <= `DCAU_MCAND_RST;
            dout_reg <= `DCAU_DOUT_RST;
            dout_vld_reg <= 1'b0;
            br_vld_reg <= 1'b0;
            br_tkn_reg <= 1'b0;
            wrap_reg <= 1'b0;
            sat_reg <= 1'b0;
            intb_reg <= 1'b0;
        end else begin
            acc_reg <= acc_next;
            prod_reg <= prod_next;
            mcand_reg <= mcand_next;
            dout_reg <= dout_next;
            dout_vld_reg <= dout_vld_next;
            br_vld_reg <= br_vld_next;
            br_tkn_reg <= br_tkn_next;
            wrap_reg <= wrap_next;
            sat_reg <= sat_next;
            intb_reg <= intb_next;
        end
    end

    assign ACC = acc_reg;
    assign PRODUCT = prod_reg;
    assign MCAND = mcand_reg;
    assign DATA_OUT = dout_reg;
    assign DATA_OUT_VALID = dout_vld_reg;
    assign BRANCH_VALID = br_vld_reg;
    assign BRANCH_TAKEN = br_tkn_reg;
    assign WRAP_FLAG = wrap_reg;
    assign SAT_ENABLE = sat_reg;
    assign INT_BLOCK = intb_reg;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    AST_STORE_HIGH_KEEPS_ACC: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && CMD.op == OP_STORE_HIGH_WORD |=> DATA_OUT_VALID && ACC == $past(ACC))
        else $error("store high changed accumulator or gave no word");
    AST_OUT_SHIFT_FOUR: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && CMD.op == OP_STORE_HIGH_WORD && CMD.out_shift == OSH_4
        |=> DATA_OUT == $past(ACC[27:12]))
        else $error("store high shift by four wrong");
    AST_AND_UPPER_ZERO: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && CMD.op == OP_AND |=> ACC[31:16] == 16'h0000)
        else $error("and left upper half nonzero");
    AST_LOGIC_NO_WRAP: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && (CMD.op == OP_XOR || CMD.op == OP_OR) && !WRAP_FLAG |=> !WRAP_FLAG)
        else $error("logic op raised overflow");
    AST_SAT_CLAMP: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && alu.ovf && SAT_ENABLE
        |=> ACC == ($past(acc_reg[31]) ? `DCAU_SAT_MIN : `DCAU_SAT_MAX))
        else $error("saturated value wrong");
    AST_WRAP_SETS_FLAG: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && alu.ovf |=> WRAP_FLAG ##1 (WRAP_FLAG || $past(CMD.op) inside
        {OP_BRANCH_ON_WRAP, OP_LOAD_STATUS}))
        else $error("overflow flag not sticky");
    AST_BRANCH_WRAP: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && CMD.op == OP_BRANCH_ON_WRAP
        |=> BRANCH_VALID && BRANCH_TAKEN == $past(WRAP_FLAG) && !WRAP_FLAG)
        else $error("branch on overflow wrong");
    AST_MUL_PRODUCT: assert property (@(posedge CLK) disable iff (!RSTN)
        CMD_VALID && CMD.op == OP_MULTIPLY_BY_WORD
        |=> PRODUCT == (($past(MCAND) == `DCAU_MUL_MIN_WORD &&
                         $past(DATA_IN) == `DCAU_MUL_MIN_WORD) ? `DCAU_MUL_CORNER
                        : 32'($signed($past(MCAND)) * $signed($past(DATA_IN)))))
        else $error("product wrong");
    AST_INT_BLOCK: assert property (@(posedge CLK) disable iff (!RSTN)
        is_mul |=> INT_BLOCK ##1 (INT_BLOCK || $past(CMD_VALID)))
        else $error("interrupt block dropped early");

endmodule

/* verif/dcau_mem_model.sv */
// data memory model that takes the accumulator stores
`timescale 1ns/1ps

module dcau_mem_model (
    input wire logic clk, // processor clock
    input wire logic rstn, // synchronous reset, active low
    input wire logic [15:0] wr_data, // word from the datapath
    input wire logic wr_en, // one-cycle store strobe
    output logic [15:0] last_word, // most recent word stored
    output logic [7:0] n_stores // stores since reset
);
    // one 16-bit word per store strobe, accumulator halves arrive apart
    always @(posedge clk) begin
        if (!rstn) begin
            last_word <= 16'h0000;
            n_stores <= 8'h00;
        end else if (wr_en) begin
            last_word <= wr_data;
            n_stores <= n_stores + 8'h01;
        end
    end
endmodule

/* verif/tb_dsp_central_arith_unit.sv */
// self-checking bench of the central arithmetic datapath
`timescale 1ns/1ps

module tb_dsp_central_arith_unit import dcau_pkg::*;;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic cmd_valid = 1'b0;
    dcau_cmd_t cmd = '0;
    logic [15:0] data_in = 16'h0000;
    logic [31:0] acc, product;
    logic [15:0] mcand, data_out, mem_word;
    logic data_out_valid, branch_valid, branch_taken, wrap_flag, sat_enable, int_block;
    int failures = 0;
    int n_tests = 0;

    always #5 clk = ~clk;

    dcau_core u_dcau_core (.CLK(clk), .RSTN(rstn), .CMD_VALID(cmd_valid), .CMD(cmd),
        .DATA_IN(data_in), .ACC(acc), .PRODUCT(product), .MCAND(mcand), .DATA_OUT(data_out),
        .DATA_OUT_VALID(data_out_valid), .BRANCH_VALID(branch_valid),
        .BRANCH_TAKEN(branch_taken), .WRAP_FLAG(wrap_flag), .SAT_ENABLE(sat_enable),
        .INT_BLOCK(int_block));

    dcau_mem_model u_dcau_mem_model (.clk(clk), .rstn(rstn), .wr_data(data_out),
        .wr_en(data_out_valid), .last_word(mem_word), .n_stores());

    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // wide enough for the widest packed group compared at once
    task automatic check(input logic [95:0] seen, input logic [95:0] exp, input string what);
        n_tests++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH at %0t: %s got %h want %h", $time, what, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("comparisons %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // results are settled one delay after the taking edge
    task automatic issue(input dcau_op_t op, input logic [15:0] w, input logic [4:0] sh = 5'h00,
        input dcau_oshift_t osh = OSH_0, input dcau_cond_t c = BR_IF_NEGATIVE,
        input logic [12:0] k = 13'h0000);
        @(posedge clk);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op, sh, osh, c, k};
        data_in = w;
        @(posedge clk);
        #1;
        cmd_valid = 1'b0;
    endtask

    task automatic store(input dcau_op_t op, input dcau_oshift_t osh, input logic [15:0] exp);
        logic [31:0] acc_before;
        acc_before = acc;
        issue(op, 16'h0000, 5'h00, osh);
        check(data_out_valid, 1'b1, "store strobe");
        check(data_out, exp, "stored word");
        check(acc, acc_before, "acc after store");
        @(posedge clk);
        #1;
        check(data_out_valid, 1'b0, "strobe length");
        check(mem_word, exp, "memory word");
    endtask

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_load;
        issue(OP_LOAD_SHIFTED, 16'h7EBC, 5'h04);
        check(acc, 32'h0007_EBC0, "load shift 4");
        issue(OP_LOAD_SHIFTED, 16'h8EBC, 5'h08);
        check(acc, 32'hFF8E_BC00, "load shift 8");
        issue(OP_ADD, 16'hFFFF, 5'h10);
        check(acc, 32'hFF8D_BC00, "add shift 16");
    endtask

    task automatic t_store;
        dcau_oshift_t sh_t[4] = '{OSH_4, OSH_1, OSH_0, OSH_BAD};
        logic [15:0] hi_t[4] = '{16'h34B7, 16'h4696, 16'hA34B, 16'hA34B};
        issue(OP_LOAD_SHIFTED, 16'hA34B, 5'h10);
        issue(OP_ADD_NO_SIGN_EXTEND, 16'h78CD);
        check(acc, 32'hA34B_78CD, "unsigned add");
        issue(OP_SUBTRACT_NO_SIGN_EXTEND, 16'hFFFF);
        check(acc, 32'hA34A_78CE, "unsigned sub");
        issue(OP_ADD_NO_SIGN_EXTEND, 16'hFFFF);
        for (int i = 0; i < 4; i++) begin
            store(OP_STORE_HIGH_WORD, sh_t[i], hi_t[i]);
        end
        store(OP_STORE_LOW_WORD, OSH_0, 16'h78CD);
    endtask

    task automatic t_logic;
        dcau_op_t op_t[3] = '{OP_XOR, OP_OR, OP_AND};
        logic [15:0] w_t[3] = '{16'hFFFF, 16'h00F0, 16'h0F0F};
        logic [31:0] r_t[3] = '{32'hA34B_8732, 32'hA34B_87F2, 32'h0000_0702};
        issue(OP_SET_SATURATION, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            issue(op_t[i], w_t[i]);
            check(acc, r_t[i], "logic result");
            check(wrap_flag, 1'b0, "logic never wraps");
        end
    endtask

    task automatic t_sat;
        issue(OP_CLEAR_SATURATION, 16'h0000);
        check(sat_enable, 1'b0, "sat cleared");
        issue(OP_LOAD_SHIFTED, 16'h7FFF, 5'h10);
        issue(OP_ADD, 16'h7FFF, 5'h10);
        check(acc, 32'hFFFE_0000, "wrapped sum");
        check(wrap_flag, 1'b1, "flag on wrap");
        issue(OP_XOR, 16'h0000);
        check(wrap_flag, 1'b1, "flag sticky");
        issue(OP_BRANCH_ON_WRAP, 16'h0000);
        check({branch_valid, branch_taken, wrap_flag}, 3'b110, "branch on wrap");
        issue(OP_BRANCH_ON_WRAP, 16'h0000);
        check({branch_valid, branch_taken}, 2'b10, "no wrap no branch");
        issue(OP_SET_SATURATION, 16'h0000);
        check(sat_enable, 1'b1, "sat set");
        issue(OP_LOAD_SHIFTED, 16'h7FFF, 5'h10);
        issue(OP_ADD, 16'h7FFF, 5'h10);
        check(acc, 32'h7FFF_FFFF, "positive clamp");
        check(wrap_flag, 1'b1, "flag with sat");
        issue(OP_LOAD_STATUS, 16'h0000);
        check({wrap_flag, sat_enable}, 2'b00, "status load");
        issue(OP_SET_SATURATION, 16'h0000);
        issue(OP_LOAD_SHIFTED, 16'h8000, 5'h10);
        issue(OP_SUB, 16'h0001);
        check(acc, 32'h8000_0000, "negative clamp");
        issue(OP_CLEAR_SATURATION, 16'h0000);
        store(OP_STORE_STATUS, OSH_0, 16'hBFFF);
    endtask

    task automatic t_branch;
        logic [15:0] v_t[3] = '{16'h8000, 16'h0000, 16'h0001};
        logic [5:0] m_t[3] = '{6'h13, 6'h26, 6'h1C};
        for (int v = 0; v < 3; v++) begin
            for (int c = 0; c < 6; c++) begin
                issue(OP_LOAD_SHIFTED, v_t[v]);
                issue(OP_BRANCH_COND, 16'h0000, 5'h00, OSH_0, dcau_cond_t'(c[2:0]));
                check({branch_valid, branch_taken}, {1'b1, m_t[v][c]}, "condition");
            end
        end
    endtask

    task automatic t_mult;
        issue(OP_LOAD_MULTIPLICAND, 16'h0003);
        check(mcand, 16'h0003, "multiplicand");
        issue(OP_MULTIPLY_BY_WORD, 16'hFFFE);
        check(product, 32'hFFFF_FFFA, "word product");
        check(int_block, 1'b1, "block after multiply");
        issue(OP_LOAD_PRODUCT, 16'h0000);
        check({acc, int_block}, {32'hFFFF_FFFA, 1'b0}, "load product");
        issue(OP_MULTIPLY_BY_CONSTANT, 16'h0000, 5'h00, OSH_0, BR_IF_NEGATIVE, 13'h1FFF);
        check(product, 32'hFFFF_FFFD, "constant product");
        issue(OP_ADD_PRODUCT, 16'h0000);
        check(acc, 32'hFFFF_FFF7, "add product");
        issue(OP_SUBTRACT_PRODUCT, 16'h0000);
        check(acc, 32'hFFFF_FFFA, "subtract product");
        issue(OP_LOAD_MULTIPLICAND_ADD_PRODUCT, 16'h8000);
        check({acc, mcand}, {32'hFFFF_FFF7, 16'h8000}, "pipelined accumulate");
        issue(OP_MULTIPLY_BY_WORD, 16'h8000);
        check(product, 32'h0C00_0000, "corner product");
    endtask

    // ----------------------------------------
    // main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1;
        rstn = 1'b1;
        check({acc, product, mcand, wrap_flag, sat_enable, int_block}, '0, "reset state");
        t_load();
        t_store();
        t_logic();
        t_sat();
        t_branch();
        t_mult();
        test_done();
    end

    // a hang counts as a mismatch and still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
